// [rtl/scan_tap.sv]
// boundary-scan test access port with instruction decode and pin control
// assumes tck/tms/tdi/trst_n and pins are asynchronous to ref_clk, tck well
// below ref_clk/4; config_busy, usercode and core pin controls are on ref_clk
//
// Summary of operation
// - scan test drives and captures pins only while no configuration load runs.
// - port pins are tdi, tdo, tms, tck, plus optional trst_n.
// - instruction register is ten bits; opcodes shift in ten bits.
// - sample/preload captures pin states and preloads the scan register.
// - extest drives scan register onto pins and captures input pins.
// - bypass puts a one-bit register between tdi and tdo.
// - usercode shifts the 32-bit user code out on tdo.
// - idcode shifts the identification value out on tdo.
// - highz selects bypass and releases all user pins.
// - clamp selects bypass and holds pins at scan register values.
// - reconfig pulse instruction requests reconfiguration internally, pin untouched.
// - io standard load shifts io element settings through scan chain.
// - io standard load during configuration aborts that configuration.
// - status line held low until the fifo accepts the settings word from update-dr.
// - test port also serves in-circuit reconfiguration by a host.
// - identification value: version, part, manufacturer, lsb one.
// - bus-hold keepers, when keeper_en is set, override released pins under highz, clamp and extest.
`timescale 1ns/1ps
`default_nettype none
`include "scan_tap_defs.svh"

module scan_tap import scan_tap_pkg::*; #(
   parameter int          NPINS      = 4,
   parameter int          IOE_W      = 8,
   parameter logic [3:0]  ID_VERSION = 4'h0,
   parameter logic [15:0] ID_PART    = 16'h0001,
   parameter logic [10:0] ID_MAKER   = 11'h055 // arbitrary value
)(
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic             tck,
   input  wire logic             tms,
   input  wire logic             tdi,
   input  wire logic             trst_n,
   output logic                  tdo,
   output logic                  tdo_oe,
   input  wire logic             config_busy,
   input  wire logic [31:0]      usercode,
   input  wire logic [NPINS-1:0] core_out,
   input  wire logic [NPINS-1:0] core_oe,
   input  wire logic [NPINS-1:0] pin_in,
   output logic      [NPINS-1:0] pin_out,
   output logic      [NPINS-1:0] pin_oe,
   input  wire logic             keeper_en,
   output logic                  keeper_active,
   output logic                  reconfig_pulse,
   output logic                  config_abort,
   output logic                  config_status_n,
   output logic                  io_std_valid,
   input  wire logic             io_std_ready,
   output logic      [IOE_W-1:0] io_std_data
);
   localparam int BSR_W = 2 * NPINS;
   localparam int DRW   = (BSR_W > `ID_W) ? ((BSR_W > IOE_W) ? BSR_W : IOE_W)
                                          : ((`ID_W > IOE_W) ? `ID_W : IOE_W);
   localparam logic [`ID_W-1:0] IDCODE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

   logic [1:0]         rst_q_r;
   logic               rst_n;
   logic [3:0]         sync1_r;
   logic [3:0]         sync2_r;
   logic               tck_d_r;
   logic [NPINS-1:0]   pin_s1_r;
   logic [NPINS-1:0]   pin_s2_r;
   logic               tck_s, tms_s, tdi_s, trst_s;
   logic               tck_rise, tck_fall;
   tap_state_t         state_r, state_nxt;
   logic [`IR_W-1:0]   ir_sh_r;
   logic [`IR_W-1:0]   ir_r;
   dr_sel_t            dr_sel;
   logic               bsr_drive, pins_hiz;
   int                 dr_len;
   logic [DRW-1:0]     dr_sh_r;
   logic [DRW-1:0]     dr_shifted;
   logic [DRW-1:0]     dr_cap;
   logic [BSR_W-1:0]   bsr_upd_r;
   logic [IOE_W-1:0]   ioe_upd_r;
   logic               ioe_pend_r;
   logic               ioe_in_ready;
   logic               ioe_acc;
   logic               scan_ok;
   logic               tick;
   logic               tdo_r, tdo_oe_r;
   logic [NPINS-1:0]   pin_out_r, pin_oe_r;
   logic               keep_r, pulse_r, abort_r, stat_n_r;

   // reset release through two flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_q_r <= 2'b00;
      end else begin
         rst_q_r <= {rst_q_r[0], 1'b1};
      end
   end
   assign rst_n = rst_q_r[1];

   // test port pins synchronised; first stage read only by second
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r  <= 4'h0;
         sync2_r  <= 4'h0;
         tck_d_r  <= 1'b0;
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         sync1_r  <= {trst_n, tdi, tms, tck};
         sync2_r  <= sync1_r;
         tck_d_r  <= sync2_r[0];
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end
   assign tck_s    = sync2_r[0];
   assign tms_s    = sync2_r[1];
   assign tdi_s    = sync2_r[2];
   assign trst_s   = sync2_r[3];
   assign tck_rise = tck_s & ~tck_d_r;
   assign tck_fall = ~tck_s & tck_d_r;
   // a tck rising edge seen while test reset is released
   assign tick     = tck_rise & trst_s;
   // no pin test action while configuration loads
   assign scan_ok  = ~config_busy;

   // tap controller next state on tms
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         TLR:        state_nxt = tms_s ? TLR : RTI;
         RTI:        state_nxt = tms_s ? SEL_DR : RTI;
         SEL_DR:     state_nxt = tms_s ? SEL_IR : CAPTURE_DR;
         CAPTURE_DR: state_nxt = tms_s ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR:   state_nxt = tms_s ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR:   state_nxt = tms_s ? UPDATE_DR : PAUSE_DR;
         PAUSE_DR:   state_nxt = tms_s ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR:   state_nxt = tms_s ? UPDATE_DR : SHIFT_DR;
         UPDATE_DR:  state_nxt = tms_s ? SEL_DR : RTI;
         SEL_IR:     state_nxt = tms_s ? TLR : CAPTURE_IR;
         CAPTURE_IR: state_nxt = tms_s ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR:   state_nxt = tms_s ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR:   state_nxt = tms_s ? UPDATE_IR : PAUSE_IR;
         PAUSE_IR:   state_nxt = tms_s ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR:   state_nxt = tms_s ? UPDATE_IR : SHIFT_IR;
         UPDATE_IR:  state_nxt = tms_s ? SEL_DR : RTI;
         default:    state_nxt = TLR;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= TLR;
      end else if (!trst_s) begin
         state_r <= TLR;
      end else if (tck_rise) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_sh_r <= `IR_CAPTURE;
         ir_r    <= `OP_IDCODE;
      end else if (state_r == TLR) begin
         ir_r <= `OP_IDCODE;
      end else if (tick) begin
         case (state_r)
            CAPTURE_IR: ir_sh_r <= `IR_CAPTURE;
            SHIFT_IR:   ir_sh_r <= {tdi_s, ir_sh_r[`IR_W-1:1]};
            UPDATE_IR:  ir_r <= ir_sh_r;
            default:    ir_sh_r <= ir_sh_r;
         endcase
      end
   end

   // instruction decode into path select and pin mode
   always_comb begin
      dr_sel    = DR_BYP;
      bsr_drive = 1'b0;
      pins_hiz  = 1'b0;
      case (ir_r)
         `OP_SAMPLE:    dr_sel = DR_BSR;
         // extest drives pins from the scan register
         `OP_EXTEST: begin
            dr_sel    = DR_BSR;
            bsr_drive = 1'b1;
         end
         `OP_USERCODE:  dr_sel = DR_USER;
         `OP_IDCODE:    dr_sel = DR_ID;
         `OP_HIGHZ:     pins_hiz = 1'b1;
         `OP_CLAMP:     bsr_drive = 1'b1;
         `OP_CONFIG_IO: dr_sel = DR_IOE;
         // bypass, reconfig pulse and unknown codes
         default:       dr_sel = DR_BYP;
      endcase
   end

   // length of the selected data register
   always_comb begin
      case (dr_sel)
         DR_ID:   dr_len = `ID_W;
         DR_USER: dr_len = `USER_W;
         DR_BSR:  dr_len = BSR_W;
         DR_IOE:  dr_len = IOE_W;
         default: dr_len = `BYP_W;
      endcase
   end

   // capture values; id layout, enable cells then pin cells for the bsr
   always_comb begin
      case (dr_sel)
         DR_ID:   dr_cap = DRW'(IDCODE);
         DR_USER: dr_cap = DRW'(usercode);
         DR_BSR:  dr_cap = DRW'({core_oe, pin_s2_r});
         DR_IOE:  dr_cap = DRW'(ioe_upd_r);
         default: dr_cap = '0;
      endcase
   end

   // tdi enters at the top of the selected length, lsb leaves on tdo
   always_comb begin
      dr_shifted = {1'b0, dr_sh_r[DRW-1:1]};
      dr_shifted[dr_len - 1] = tdi_s;
   end

   // one shared shift register for all data paths
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dr_sh_r <= '0;
      end else if (tick && state_r == CAPTURE_DR) begin
         // scan register skips its capture while configuration loads; shifting still runs
         if (dr_sel != DR_BSR || scan_ok) begin
            dr_sh_r <= dr_cap;
         end
      end else if (tick && state_r == SHIFT_DR) begin
         // one stage of delay when bypass is selected
         dr_sh_r <= dr_shifted;
      end
   end

   // preload or test pattern lands in the update stage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bsr_upd_r <= '0;
      end else if (tick && state_r == UPDATE_DR && dr_sel == DR_BSR && scan_ok) begin
         bsr_upd_r <= dr_sh_r[BSR_W-1:0];
      end
   end

   // settings word waits here until the fifo takes it
   assign ioe_acc = ioe_pend_r & ioe_in_ready;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ioe_pend_r <= 1'b0;
         ioe_upd_r  <= '0;
      end else if (tick && state_r == UPDATE_DR && dr_sel == DR_IOE) begin
         ioe_pend_r <= 1'b1;
         ioe_upd_r  <= dr_sh_r[IOE_W-1:0];
      end else if (ioe_acc) begin
         ioe_pend_r <= 1'b0;
      end
   end

   // consumer may stall; a full fifo holds the status line low longer
   scan_fifo #(
      .WIDTH (IOE_W),
      .DEPTH (`IOE_FIFO_D)
   ) u_ioe_fifo (
      .clk       (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (ioe_pend_r),
      .in_ready  (ioe_in_ready),
      .in_data   (ioe_upd_r),
      .out_valid (io_std_valid),
      .out_ready (io_std_ready),
      .out_data  (io_std_data)
   );

   // status low from instruction load until settings accepted
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_n_r <= 1'b1;
      end else if (tick && state_r == UPDATE_IR && ir_sh_r == `OP_CONFIG_IO) begin
         stat_n_r <= 1'b0;
      end else if (ioe_acc || state_r == TLR) begin
         stat_n_r <= 1'b1;
      end
   end

   // one-cycle requests to the configuration logic
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         pulse_r <= tick && state_r == UPDATE_IR && ir_sh_r == `OP_PULSE;
         abort_r <= tick && state_r == UPDATE_IR && ir_sh_r == `OP_CONFIG_IO
                    && config_busy;
      end
   end

   // tdo changes on the falling edge, driven only in shift states
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (!trst_s) begin
         tdo_oe_r <= 1'b0;
      end else if (tck_fall) begin
         tdo_r    <= (state_r == SHIFT_IR) ? ir_sh_r[0] : dr_sh_r[0];
         tdo_oe_r <= (state_r == SHIFT_IR) || (state_r == SHIFT_DR);
      end
   end

   // pin control; core keeps the pins while configuration loads
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_r <= '0;
         pin_oe_r  <= '0;
         keep_r    <= 1'b0;
      end else if (scan_ok && pins_hiz) begin
         pin_out_r <= core_out;
         pin_oe_r  <= '0;
         keep_r    <= keeper_en;
      end else if (scan_ok && bsr_drive) begin
         pin_out_r <= bsr_upd_r[NPINS-1:0];
         pin_oe_r  <= bsr_upd_r[BSR_W-1:NPINS];
         // keepers win over cells that release the pin
         keep_r    <= keeper_en;
      end else begin
         pin_out_r <= core_out;
         pin_oe_r  <= core_oe;
         keep_r    <= 1'b0;
      end
   end

   assign tdo             = tdo_r;
   assign tdo_oe          = tdo_oe_r;
   assign pin_out         = pin_out_r;
   assign pin_oe          = pin_oe_r;
   assign keeper_active   = keep_r;
   assign reconfig_pulse  = pulse_r;
   assign config_abort    = abort_r;
   assign config_status_n = stat_n_r;

   // checks on the decoded behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_ir_update_load: assert property (
      tick && state_r == UPDATE_IR |=> ir_r == $past(ir_sh_r))
      else $error("instruction not loaded at update-ir");
   a_reset_idcode: assert property (
      !trst_s |=> ##1 ir_r == `OP_IDCODE && state_r == TLR)
      else $error("test reset did not select idcode");
   a_bypass_delay: assert property (
      tick && state_r == SHIFT_DR && dr_sel == DR_BYP |=> dr_sh_r[0] == $past(tdi_s))
      else $error("bypass stage not one bit");
   a_undefined_bypass: assert property (
      !(ir_r inside {`OP_PULSE, `OP_SAMPLE, `OP_IDCODE, `OP_USERCODE, `OP_CLAMP,
                     `OP_HIGHZ, `OP_CONFIG_IO, `OP_EXTEST})
      |-> dr_sel == DR_BYP && !bsr_drive && !pins_hiz)
      else $error("unknown opcode not bypass");
   a_id_capture: assert property (
      tick && state_r == CAPTURE_DR && ir_r == `OP_IDCODE
      |=> dr_sh_r[`ID_W-1:0] == IDCODE && dr_sh_r[0])
      else $error("idcode capture wrong");
   a_user_capture: assert property (
      tick && state_r == CAPTURE_DR && ir_r == `OP_USERCODE
      |=> dr_sh_r[`USER_W-1:0] == $past(usercode))
      else $error("usercode capture wrong");
   a_highz_release: assert property (
      ir_r == `OP_HIGHZ && scan_ok |=> pin_oe == '0 && keeper_active == $past(keeper_en))
      else $error("pins not released under highz");
   a_clamp_hold: assert property (
      ir_r == `OP_CLAMP && scan_ok
      |=> pin_out == $past(bsr_upd_r[NPINS-1:0]) && pin_oe == $past(bsr_upd_r[BSR_W-1:NPINS]))
      else $error("clamp does not hold scan values");
   a_busy_core_pins: assert property (
      config_busy |=> pin_oe == $past(core_oe) && pin_out == $past(core_out))
      else $error("pin test active during configuration");
   a_pulse_single: assert property (
      reconfig_pulse |=> !reconfig_pulse)
      else $error("reconfig pulse longer than one cycle");
   a_abort_busy: assert property (
      tick && state_r == UPDATE_IR && ir_sh_r == `OP_CONFIG_IO && config_busy
      |=> config_abort && !config_status_n)
      else $error("configuration not aborted");
   a_status_held: assert property (
      !config_status_n && !ioe_acc && state_r != TLR |=> !config_status_n)
      else $error("status released before settings loaded");

   c_extest_load: cover property (tick && state_r == UPDATE_IR && ir_sh_r == `OP_EXTEST);
   c_ioe_push:    cover property (ioe_acc ##1 config_status_n);
   c_fifo_full:   cover property (ioe_pend_r && !ioe_in_ready);
   c_pulse:       cover property (reconfig_pulse);

endmodule : scan_tap

`default_nettype wire

// [rtl/scan_tap_defs.svh]
// constants for the boundary-scan test port: opcodes, widths, capture values
// assumes inclusion by bare name from the test port design files
`ifndef SCAN_TAP_DEFS_SVH
`define SCAN_TAP_DEFS_SVH

// instruction register
`define IR_W          10
`define IR_CAPTURE    10'h001

// instruction opcodes
`define OP_PULSE      10'h001
`define OP_SAMPLE     10'h005
`define OP_IDCODE     10'h006
`define OP_USERCODE   10'h007
`define OP_CLAMP      10'h00a
`define OP_HIGHZ      10'h00b
`define OP_CONFIG_IO  10'h00d
`define OP_EXTEST     10'h00f
`define OP_BYPASS     10'h3ff

// data register lengths
`define ID_W          32
`define USER_W        32
`define BYP_W         1

// fifo depth in front of the io element settings consumer
`define IOE_FIFO_D    4

`endif

// [rtl/scan_tap_pkg.sv]
// types shared by the boundary-scan test port
// assumes nothing beyond a systemverilog compiler
package scan_tap_pkg;

   // tap controller states
   typedef enum logic [3:0] {
      TLR        = 4'h0,
      RTI        = 4'h1,
      SEL_DR     = 4'h2,
      CAPTURE_DR = 4'h3,
      SHIFT_DR   = 4'h4,
      EXIT1_DR   = 4'h5,
      PAUSE_DR   = 4'h6,
      EXIT2_DR   = 4'h7,
      UPDATE_DR  = 4'h8,
      SEL_IR     = 4'h9,
      CAPTURE_IR = 4'ha,
      SHIFT_IR   = 4'hb,
      EXIT1_IR   = 4'hc,
      PAUSE_IR   = 4'hd,
      EXIT2_IR   = 4'he,
      UPDATE_IR  = 4'hf
   } tap_state_t;

   // data register selected by the instruction
   typedef enum logic [2:0] {
      DR_BYP  = 3'h0,
      DR_ID   = 3'h1,
      DR_USER = 3'h2,
      DR_BSR  = 3'h3,
      DR_IOE  = 3'h4
   } dr_sel_t;

endpackage : scan_tap_pkg

// [rtl/scan_fifo.sv]
// small first-word-fall-through fifo, flip-flop storage
// assumes one clock and a synchronous active-low reset copy from the parent
`timescale 1ns/1ps
`default_nettype none

module scan_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [CW-1:0]    cnt_r;
   logic             push;
   logic             pop;

   // honest full and empty from the occupancy count
   assign in_ready  = (cnt_r != CW'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_r[rd_r];

   // storage, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
      end
   end

   // occupancy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (push && !pop) begin
         cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

endmodule : scan_fifo

`default_nettype wire

// [tb/jtag_host.sv]
// test host model driving the scan port pins, tck period 125 ns
// assumes the bench calls one task at a time; tck stands low between frames
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // idle levels: tck low, pulled-up lines released high
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // one tck period; tdo taken on the rising edge
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #62.5 tck = 1'b1;
      q = tdo;
      #62.5 tck = 1'b0;
   endtask : step

   // five ones always reach test-logic-reset, then idle
   task automatic tap_reset();
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask : tap_reset

   // lsb-first scan from idle back to idle; tdi released high after
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask : scan
endmodule : jtag_host
`default_nettype wire

// [tb/scan_tap_bench.sv]
// self-checking bench for the boundary-scan test port
// assumes jtag_host on the link; the bench plays core and settings consumer
`timescale 1ns/1ps
`default_nettype none
`include "scan_tap_defs.svh"
module scan_tap_bench;
   logic        ref_clk, resetn, tck, tms, tdi, trst_n, tdo, tdo_oe, config_busy;
   logic        keeper_en, keeper_active, reconfig_pulse, config_abort, config_status_n;
   logic        io_std_valid, io_std_ready, hold_ready;
   logic [31:0] usercode, seed, dout, w;
   logic [3:0]  core_out, core_oe, pin_in, pin_out, pin_oe;
   logic [7:0]  io_std_data, d;
   logic [9:0]  ops[4];
   logic [7:0]  exp_q[$];
   int          fail_count, check_count, pulse_cnt, abort_cnt, rcv;
   localparam logic [31:0] ID_EXP = {4'h0, 16'h0001, 11'h055, 1'b1};

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   scan_tap i_dut (.ref_clk, .resetn, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe,
      .config_busy, .usercode, .core_out, .core_oe, .pin_in, .pin_out, .pin_oe,
      .keeper_en, .keeper_active, .reconfig_pulse, .config_abort, .config_status_n,
      .io_std_valid, .io_std_ready, .io_std_data);
   jtag_host i_host (.tck, .tms, .tdi, .tdo);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // bypass answer: one stage late, captured zero first
   function automatic logic [7:0] byp_exp(input logic [7:0] v);
      return {v[6:0], 1'b0};
   endfunction : byp_exp

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   // every instruction load also reads back the capture pattern
   task automatic ld(input logic [9:0] o);
      i_host.scan(1'b1, 10, {22'h0, o}, dout);
      check(dout[9:0], `IR_CAPTURE);
      check(tdo_oe, 1'b0);
   endtask : ld

   // pulses and consumer sampled mid-cycle, clear of the edge
   always @(negedge ref_clk) begin
      if (reconfig_pulse === 1'b1) pulse_cnt++;
      if (config_abort === 1'b1) abort_cnt++;
      if (io_std_valid === 1'b1 && io_std_ready === 1'b1) begin
         check(io_std_data, exp_q.pop_front());
         rcv++;
      end
   end

   // consumer stalls at random once released
   always @(posedge ref_clk) #1 io_std_ready = hold_ready ? 1'b0 : 1'($random(seed));

   initial begin
      #900000;
      fail_count++;
      tally_and_finish();
   end

   initial begin
      seed = 32'h03777670;
      {resetn, config_busy, io_std_ready} = 3'h0;
      {trst_n, keeper_en, hold_ready} = 3'h7;
      usercode = $random(seed);
      {core_out, core_oe, pin_in} = 12'($random(seed));
      {fail_count, check_count, pulse_cnt, abort_cnt, rcv} = '0;
      tick(6);
      resetn = 1'b1;
      tick(6);
      i_host.tap_reset();
      i_host.scan(1'b0, 32, 32'h0, dout);
      check(dout, ID_EXP);
      ld(`OP_USERCODE);
      i_host.scan(1'b0, 32, 32'h0, dout);
      check(dout, usercode);
      $display("test id and user code done");
      // capture pins while the core still owns them, preload a pattern
      ld(`OP_SAMPLE);
      d = 8'($random(seed));
      i_host.scan(1'b0, 8, {24'h0, d}, dout);
      check(dout[7:0], {core_oe, pin_in});
      check({pin_oe, pin_out}, {core_oe, core_out});
      ops = '{`OP_BYPASS, {1'b1, 9'($random(seed))}, `OP_HIGHZ, `OP_CLAMP};
      foreach (ops[k]) begin
         // keepers on for highz, off for clamp, so both levels are seen
         tick(1);
         keeper_en = ops[k][0];
         ld(ops[k]);
         w = $random(seed);
         i_host.scan(1'b0, 8, w, dout);
         check(dout[7:0], byp_exp(w[7:0]));
         if (ops[k] == `OP_HIGHZ) check({pin_oe, keeper_active}, 5'h01);
         if (ops[k] == `OP_CLAMP) check({pin_oe, pin_out, keeper_active}, {d, 1'b0});
      end
      $display("test bypass family done");
      ld(`OP_EXTEST);
      i_host.scan(1'b0, 8, w, dout);
      check(dout[3:0], pin_in);
      check({pin_oe, pin_out}, w[7:0]);
      tick(1);
      config_busy = 1'b1;
      tick(4);
      check({pin_oe, pin_out}, {core_oe, core_out});
      config_busy = 1'b0;
      ld(`OP_PULSE);
      check(pulse_cnt, 1);
      $display("test extest and pulse done");
      // settings load during configuration, consumer stalled past full
      tick(1);
      config_busy = 1'b1;
      ld(`OP_CONFIG_IO);
      check({abort_cnt[3:0], config_status_n}, 5'h02);
      tick(1);
      config_busy = 1'b0;
      for (int i = 0; i < 5; i++) begin
         d = 8'($random(seed));
         exp_q.push_back(d);
         i_host.scan(1'b0, 8, {24'h0, d}, dout);
         check(config_status_n, 1'b1);
      end
      check(rcv, 0);
      hold_ready = 1'b0;
      for (int t = 0; t < 300 && rcv < 5; t++) tick(1);
      tick(2);
      check({rcv[3:0], io_std_valid}, 5'h0a);
      $display("test settings stream done");
      // test reset must undo a pin-driving mode, not just an idle one
      ld(`OP_CLAMP);
      check({pin_oe, pin_out}, w[7:0]);
      trst_n = 1'b0;
      tick(4);
      trst_n = 1'b1;
      tick(6);
      check({pin_oe, pin_out}, {core_oe, core_out});
      // one step to idle only, so the id read proves test reset loaded it
      i_host.step(1'b0, 1'b1, dout[0]);
      i_host.scan(1'b0, 32, 32'h0, dout);
      check(dout, ID_EXP);
      $display("test test reset done");
      tally_and_finish();
   end
endmodule : scan_tap_bench
`default_nettype wire
